// File: abr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module abr_host_model #(
  parameter int NCH = 16
) (
  input wire logic i_mclk,
  output logic o_tx_valid,
  output logic [$clog2(NCH)-1:0] o_tx_chan,
  output logic o_tx_pending,
  output logic [15:0] o_tx_status,
  output logic [1:0] o_tx_boff
);
  initial begin
    o_tx_valid = 1'b0;
    o_tx_chan = '0;
    o_tx_pending = 1'b0;
    o_tx_status = 16'h0000;
    o_tx_boff = 2'h0;
  end
  // ==========================================================
  // Cell hand-over
  // Released status and byte-offset fields show their inverse, so stale values cannot pass; channel and pending keep their values.
  task automatic send(input logic [$clog2(NCH)-1:0] ch, input logic pend,
                      input logic [15:0] st, input logic [1:0] bo);
    @(posedge i_mclk);
    o_tx_valid <= 1'b1;
    o_tx_chan <= ch;
    o_tx_pending <= pend;
    o_tx_status <= st & 16'hC003;
    o_tx_boff <= bo;
    @(posedge i_mclk);
    o_tx_valid <= 1'b0;
    o_tx_status <= ~(st & 16'hC003);
    o_tx_boff <= ~bo;
  endtask
endmodule
`default_nettype wire

// File: abr_pkg.sv
package abr_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] ABR_CTRL_OFS = 12'h000;
  localparam logic [11:0] ABR_MOVE_OFS = 12'h004;
  localparam logic [11:0] ABR_PURGE_OFS = 12'h008;
  localparam logic [11:0] ABR_RANGE_OFS = 12'h00C;
  localparam logic [11:0] ABR_RMSTAT_OFS = 12'h010;
  localparam logic [3:0] ABR_PROF_PAGE = 4'h1;
  localparam logic [3:0] ABR_CFG_PAGE = 4'h2;
  localparam logic [3:0] ABR_RELOAD_PAGE = 4'h3;
  localparam logic [3:0] ABR_STATE_PAGE = 4'h4;

  // ==========================================================
  // Field positions and reset values
  localparam int ABR_CTRL_AUTO = 0;
  localparam int ABR_CTRL_RMFWD = 1;
  localparam int ABR_CTRL_HDRONLY = 2;
  localparam int ABR_CTRL_CRC10 = 3;
  localparam logic [3:0] ABR_CTRL_RST = 4'h1;
  localparam logic [31:0] ABR_RANGE_RST = 32'h00FF_FFFF;
  localparam logic [31:0] ABR_HDR_FIXED = 32'h0000_000F;
  localparam int ABR_MOVE_PROF_LSB = 16;
  localparam int ABR_PURGE_ALL = 16;
  localparam int TXD_EOF = 0;
  localparam int TXD_MORE = 1;
  localparam int TXD_PT = 14;
  localparam int TXD_CT = 15;
  localparam int LD_RM_RCVD = 0;
  localparam int LD_EFCI0 = 1;
  localparam int LD_EMPTY = 4;
  localparam int LD_DELETE = 5;
  localparam int LD_OFF = 6;
  localparam int LD_SEND_RM = 7;
  localparam int ABR_NUM_PROF = 32;

  // ==========================================================
  // Reserved channels and cell codes
  localparam logic [11:0] ABR_CH_OAM = 12'h000;
  localparam logic [11:0] ABR_CH_RM = 12'h001;
  localparam logic [11:0] ABR_CH_DUMP = 12'h002;
  localparam logic [2:0] ABR_PTI_F5_SEG = 3'h4;
  localparam logic [2:0] ABR_PTI_F5_E2E = 3'h5;
  localparam logic [2:0] ABR_PTI_RM = 3'h6;
  localparam logic [2:0] ABR_PTI_BAD = 3'h7;

  typedef enum logic [1:0] {ABR_KIND_CBR, ABR_KIND_VBR, ABR_KIND_ABR}
    abr_kind_type;

  typedef struct packed {
    logic [7:0] nrm_f;
    logic [7:0] adr_f;
    logic [4:0] incr;
    abr_kind_type kind;
  } abr_prof_type;

  typedef struct packed {
    logic [4:0] maxp;
    logic [4:0] minp;
    logic [4:0] initp;
  } abr_cfg_type;

  typedef struct packed {
    logic valid;
    logic [11:0] chan;
    logic cell_transparent;
    logic hdr_only;
    logic crc10_check;
  } abr_route_type;

  typedef struct packed {
    logic valid;
    logic efci;
    logic [4:0] profile;
    logic eof;
    logic more;
    logic pt;
    logic ct;
    logic [3:0] first_be;
  } abr_txcell_type;

endpackage

// File: abr_traffic.sv
`timescale 1ns/1ps
`default_nettype none
module abr_traffic #(
  parameter int NCH = 16,
  parameter int RMCNT_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tx_valid,
  input wire logic [$clog2(NCH)-1:0] i_tx_chan,
  input wire logic i_tx_pending,
  input wire logic [15:0] i_tx_status,
  input wire logic [1:0] i_tx_boff,
  output abr_pkg::abr_txcell_type o_tx_cell,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_hdr,
  input wire logic i_rx_desc_ok,
  input wire logic [11:0] i_rx_chan,
  output abr_pkg::abr_route_type o_rx_route,
  input wire logic i_rm_drain,
  output logic o_rm_sched,
  output logic o_rm_qappend,
  output logic o_purge_valid,
  output logic [11:0] o_purge_chan,
  output logic o_purge_all
);

  localparam int CW = $clog2(NCH);

  // ==========================================================
  // Register storage
  logic [3:0] ctrl;
  logic [31:0] move_reg;
  logic [31:0] supported_header_range;
  abr_pkg::abr_prof_type prof [abr_pkg::ABR_NUM_PROF];
  abr_pkg::abr_cfg_type cfg [NCH];
  logic [15:0] adr_rl [NCH];
  logic [15:0] nrm_rl [NCH];
  logic [4:0] cur [NCH];
  logic [4:0] copied_increase_profile [NCH];
  logic [7:0] flags [NCH];
  logic [15:0] adr_cnt [NCH];
  logic [15:0] nrm_cnt [NCH];
  logic [RMCNT_W-1:0] rm_cnt;

  logic access;
  logic wr;
  logic map_ok;
  logic idx_ok;
  logic [3:0] page;
  logic [4:0] pidx;
  logic [CW-1:0] cidx;
  logic [31:0] next_rdata;
  logic auto_en;
  logic move_wr;
  logic [CW-1:0] move_ch;
  logic [4:0] move_prof;

  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  assign page = i_paddr[11:8];
  assign pidx = i_paddr[6:2];
  assign cidx = i_paddr[2 +: CW];
  assign idx_ok = 32'(i_paddr[7:2]) < NCH;
  assign auto_en = ctrl[abr_pkg::ABR_CTRL_AUTO];
  assign move_wr = wr && i_paddr == abr_pkg::ABR_MOVE_OFS;
  assign move_ch = i_pwdata[CW-1:0];
  assign move_prof = i_pwdata[abr_pkg::ABR_MOVE_PROF_LSB +: 5];

  always_comb begin
    map_ok = 1'b0;
    next_rdata = 32'h0000_0000;
    unique case (page)
      4'h0: begin
        map_ok = 1'b1;
        unique case (i_paddr[7:0])
          abr_pkg::ABR_CTRL_OFS[7:0]: next_rdata = {28'h000_0000, ctrl};
          abr_pkg::ABR_MOVE_OFS[7:0]: next_rdata = move_reg;
          abr_pkg::ABR_PURGE_OFS[7:0]: next_rdata = 32'h0000_0000;
          abr_pkg::ABR_RANGE_OFS[7:0]: next_rdata = supported_header_range;
          abr_pkg::ABR_RMSTAT_OFS[7:0]: next_rdata = 32'(rm_cnt);
          default: map_ok = 1'b0;
        endcase
      end
      abr_pkg::ABR_PROF_PAGE: begin
        map_ok = i_paddr[7] == 1'b0;
        next_rdata = {prof[pidx].nrm_f, prof[pidx].adr_f, 3'b000,
                      prof[pidx].incr, 6'h00, prof[pidx].kind};
      end
      abr_pkg::ABR_CFG_PAGE: begin
        map_ok = idx_ok;
        next_rdata = {11'h000, cfg[cidx].maxp, 3'b000, cfg[cidx].minp,
                      3'b000, cfg[cidx].initp};
      end
      abr_pkg::ABR_RELOAD_PAGE: begin
        map_ok = idx_ok;
        next_rdata = {nrm_rl[cidx], adr_rl[cidx]};
      end
      abr_pkg::ABR_STATE_PAGE: begin
        map_ok = idx_ok;
        next_rdata = {8'h00, flags[cidx], 3'b000,
                      copied_increase_profile[cidx], 3'b000, cur[cidx]};
      end
      default: map_ok = 1'b0;
    endcase
  end

  // Zero wait states; read data is latched in the setup cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = access && !map_ok;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= next_rdata;
    end
  end

  // ==========================================================
  // Control and configuration writes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= abr_pkg::ABR_CTRL_RST;
      move_reg <= 32'h0000_0000;
      supported_header_range <= abr_pkg::ABR_RANGE_RST;
      for (int p = 0; p < abr_pkg::ABR_NUM_PROF; p++) begin
        prof[p] <= '0;
      end
      for (int c = 0; c < NCH; c++) begin
        cfg[c] <= '0;
        adr_rl[c] <= 16'h0001;
        nrm_rl[c] <= 16'h0001;
      end
    end else if (wr && map_ok) begin
      unique case (page)
        4'h0: begin
          if (i_paddr == abr_pkg::ABR_CTRL_OFS) begin
            ctrl <= i_pwdata[3:0];
          end
          if (i_paddr == abr_pkg::ABR_MOVE_OFS) begin
            move_reg <= i_pwdata;
          end
          if (i_paddr == abr_pkg::ABR_RANGE_OFS) begin
            supported_header_range <= i_pwdata;
          end
        end
        abr_pkg::ABR_PROF_PAGE: begin
          prof[pidx].kind <= abr_pkg::abr_kind_type'(i_pwdata[1:0]);
          prof[pidx].incr <= i_pwdata[12:8];
          prof[pidx].adr_f <= i_pwdata[23:16];
          prof[pidx].nrm_f <= i_pwdata[31:24];
        end
        abr_pkg::ABR_CFG_PAGE: begin
          cfg[cidx].initp <= i_pwdata[4:0];
          cfg[cidx].minp <= i_pwdata[12:8];
          cfg[cidx].maxp <= i_pwdata[20:16];
        end
        abr_pkg::ABR_RELOAD_PAGE: begin
          adr_rl[cidx] <= i_pwdata[15:0];
          nrm_rl[cidx] <= i_pwdata[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Host purge command
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_purge_valid <= 1'b0;
      o_purge_chan <= 12'h000;
      o_purge_all <= 1'b0;
    end else begin
      o_purge_valid <= wr && i_paddr == abr_pkg::ABR_PURGE_OFS;
      if (wr && i_paddr == abr_pkg::ABR_PURGE_OFS) begin
        o_purge_chan <= i_pwdata[11:0];
        o_purge_all <= i_pwdata[abr_pkg::ABR_PURGE_ALL];
      end
    end
  end

  // ==========================================================
  // Receive cell classification
  logic [2:0] pti;
  logic out_of_range;
  logic to_dump;
  logic is_f5;
  logic is_rm;
  logic rm_go;
  logic rm_to_host;
  abr_pkg::abr_route_type next_route;

  assign pti = i_rx_hdr[3:1];
  assign out_of_range =
    |(i_rx_hdr & ~(supported_header_range | abr_pkg::ABR_HDR_FIXED));
  assign to_dump = out_of_range || !i_rx_desc_ok || pti == abr_pkg::ABR_PTI_BAD;
  assign is_f5 = pti == abr_pkg::ABR_PTI_F5_SEG || pti == abr_pkg::ABR_PTI_F5_E2E;
  assign is_rm = pti == abr_pkg::ABR_PTI_RM;
  assign rm_go = i_rx_valid && !to_dump && is_rm && auto_en &&
                 32'(i_rx_chan) < NCH;

  always_comb begin
    next_route = '0;
    next_route.valid = i_rx_valid;
    next_route.chan = i_rx_chan;
    if (to_dump) begin
      next_route.chan = abr_pkg::ABR_CH_DUMP;
      next_route.cell_transparent = 1'b1;
      next_route.hdr_only = ctrl[abr_pkg::ABR_CTRL_HDRONLY];
    end else if (is_f5) begin
      next_route.chan = abr_pkg::ABR_CH_OAM;
      next_route.cell_transparent = 1'b1;
      next_route.crc10_check = ctrl[abr_pkg::ABR_CTRL_CRC10];
    end else if (is_rm) begin
      next_route.valid = i_rx_valid &&
                         (!auto_en || ctrl[abr_pkg::ABR_CTRL_RMFWD]);
      next_route.chan = abr_pkg::ABR_CH_RM;
      next_route.cell_transparent = 1'b1;
      next_route.crc10_check = ctrl[abr_pkg::ABR_CTRL_CRC10];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_route <= '0;
    end else begin
      o_rx_route <= next_route;
    end
  end

  // ==========================================================
  // RM channel occupancy
  assign rm_to_host = o_rx_route.valid && o_rx_route.chan == abr_pkg::ABR_CH_RM;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rm_cnt <= '0;
      o_rm_sched <= 1'b0;
      o_rm_qappend <= 1'b0;
    end else begin
      o_rm_sched <= rm_to_host && rm_cnt == '0;
      o_rm_qappend <= i_rm_drain && !rm_to_host && rm_cnt == RMCNT_W'(1);
      if (rm_to_host && !(i_rm_drain && rm_cnt != '0)) begin
        rm_cnt <= rm_cnt + RMCNT_W'(1);
      end else if (!rm_to_host && i_rm_drain && rm_cnt != '0) begin
        rm_cnt <= rm_cnt - RMCNT_W'(1);
      end
    end
  end

  // ==========================================================
  // Transmit-side profile movement
  logic tx_go;
  logic is_abr;
  logic nrm_exp;
  logic adr_exp;
  logic [4:0] step_val;
  logic [4:0] raise_val;
  abr_pkg::abr_prof_type pc;

  assign tx_go = i_tx_valid && 32'(i_tx_chan) < NCH;

  always_comb begin
    pc = prof[cur[i_tx_chan]];
    is_abr = pc.kind == abr_pkg::ABR_KIND_ABR;
    nrm_exp = nrm_cnt[i_tx_chan] <= 16'(pc.nrm_f);
    adr_exp = adr_cnt[i_tx_chan] <= 16'(pc.adr_f);
    step_val = cur[i_tx_chan];
    if (cur[i_tx_chan] < cfg[i_tx_chan].minp) begin
      step_val = cur[i_tx_chan] + 5'd1;
    end
    raise_val = copied_increase_profile[i_tx_chan];
    if (copied_increase_profile[i_tx_chan] < cfg[i_tx_chan].maxp) begin
      raise_val = cfg[i_tx_chan].maxp;
    end
  end

  // Later assignments override earlier ones, so a hardware flag set in the
  // same cycle as a software clear survives.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        cur[c] <= 5'd0;
        copied_increase_profile[c] <= 5'd0;
        flags[c] <= 8'h00;
        adr_cnt[c] <= 16'h0001;
        nrm_cnt[c] <= 16'h0001;
      end
    end else begin
      if (wr && page == abr_pkg::ABR_STATE_PAGE && idx_ok) begin
        flags[cidx] <= flags[cidx] & ~i_pwdata[23:16];
      end
      if (wr && page == abr_pkg::ABR_CFG_PAGE && idx_ok) begin
        cur[cidx] <= i_pwdata[4:0];
        adr_cnt[cidx] <= adr_rl[cidx];
        nrm_cnt[cidx] <= nrm_rl[cidx];
      end
      if (move_wr && 32'(move_ch) < NCH &&
          prof[cur[move_ch]].kind == abr_pkg::ABR_KIND_ABR) begin
        cur[move_ch] <= move_prof;
      end
      if (tx_go && auto_en && is_abr) begin
        if (flags[i_tx_chan][abr_pkg::LD_RM_RCVD]) begin
          cur[i_tx_chan] <= raise_val;
          flags[i_tx_chan][abr_pkg::LD_RM_RCVD] <= 1'b0;
        end else if (!i_tx_pending) begin
          // idle step down or off list
          if (cur[i_tx_chan] < cfg[i_tx_chan].initp) begin
            cur[i_tx_chan] <= step_val;
          end else begin
            flags[i_tx_chan][abr_pkg::LD_OFF] <= 1'b1;
            flags[i_tx_chan][abr_pkg::LD_EMPTY] <= 1'b1;
          end
        end else begin
          if (flags[i_tx_chan][abr_pkg::LD_OFF]) begin
            cur[i_tx_chan] <= cfg[i_tx_chan].initp;
            flags[i_tx_chan][abr_pkg::LD_OFF] <= 1'b0;
            flags[i_tx_chan][abr_pkg::LD_EMPTY] <= 1'b0;
          end else if (adr_exp) begin
            cur[i_tx_chan] <= step_val;
          end
          if (nrm_exp) begin
            nrm_cnt[i_tx_chan] <= nrm_rl[i_tx_chan];
            flags[i_tx_chan][abr_pkg::LD_EFCI0] <= 1'b1;
            copied_increase_profile[i_tx_chan] <= pc.incr;
          end else begin
            nrm_cnt[i_tx_chan] <= nrm_cnt[i_tx_chan] - 16'(pc.nrm_f);
          end
          if (adr_exp) begin
            adr_cnt[i_tx_chan] <= adr_rl[i_tx_chan];
          end else begin
            adr_cnt[i_tx_chan] <= adr_cnt[i_tx_chan] - 16'(pc.adr_f);
          end
        end
      end
      if (rm_go) begin
        flags[i_rx_chan[CW-1:0]][abr_pkg::LD_RM_RCVD] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Transmit cell attributes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_cell <= '0;
    end else begin
      o_tx_cell.valid <= tx_go;
      if (tx_go) begin
        o_tx_cell.efci <= is_abr &&
          !(auto_en && i_tx_pending && nrm_exp &&
            !flags[i_tx_chan][abr_pkg::LD_RM_RCVD] &&
            !flags[i_tx_chan][abr_pkg::LD_OFF]);
        o_tx_cell.profile <= cur[i_tx_chan];
        o_tx_cell.eof <= i_tx_status[abr_pkg::TXD_EOF];
        o_tx_cell.more <= i_tx_status[abr_pkg::TXD_MORE];
        o_tx_cell.pt <= i_tx_status[abr_pkg::TXD_PT];
        o_tx_cell.ct <= i_tx_status[abr_pkg::TXD_CT];
        o_tx_cell.first_be <= 4'hF << i_tx_boff;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence purge_written;
    wr && i_paddr == abr_pkg::ABR_PURGE_OFS;
  endsequence

  sequence purge_pulse;
    o_purge_valid ##1 !o_purge_valid;
  endsequence

  AST_PURGE_PULSE: assert property (
    purge_written ##1 !purge_written |-> purge_pulse)
    else $error("purge command did not give one pulse");

  AST_DUMP_PTI7: assert property (
    i_rx_valid && pti == 3'h7 |=> o_rx_route.valid &&
    o_rx_route.chan == 12'h002)
    else $error("PTI 7 cell not sent to dump channel");

  AST_F5_CHAN0: assert property (
    i_rx_valid && !to_dump && is_f5 |=> o_rx_route.chan == 12'h000 &&
    o_rx_route.cell_transparent)
    else $error("F5 OAM cell not on channel zero");

  AST_HDR_ONLY: assert property (
    o_rx_route.hdr_only |-> o_rx_route.chan == 12'h002 &&
    $past(ctrl[abr_pkg::ABR_CTRL_HDRONLY]))
    else $error("header-only format outside dump channel");

  AST_FIXED_PROFILE: assert property (
    tx_go && !is_abr && !move_wr && !wr |=>
    cur[$past(i_tx_chan)] == $past(cur[i_tx_chan]))
    else $error("non-ABR channel changed profile");

  AST_STEP_DOWN: assert property (
    tx_go && auto_en && is_abr && i_tx_pending && adr_exp && !wr &&
    !flags[i_tx_chan][0] && !flags[i_tx_chan][6] |=>
    $past(cur[i_tx_chan]) < $past(cfg[i_tx_chan].minp) &&
    cur[$past(i_tx_chan)] == $past(cur[i_tx_chan]) + 5'd1 ||
    $past(cur[i_tx_chan]) >= $past(cfg[i_tx_chan].minp) &&
    cur[$past(i_tx_chan)] == $past(cur[i_tx_chan]))
    else $error("rate decrease not a single bounded step");

  AST_RM_RAISE: assert property (
    tx_go && auto_en && is_abr && flags[i_tx_chan][0] && !wr && !rm_go |=>
    cur[$past(i_tx_chan)] == $past(raise_val) &&
    !flags[$past(i_tx_chan)][0])
    else $error("RM raise went to wrong profile");

  AST_EFCI_ONE: assert property (
    tx_go && is_abr && !nrm_exp |=> o_tx_cell.valid && o_tx_cell.efci)
    else $error("ABR cell sent with EFCI 0 early");

  AST_OFF_LIST: assert property (
    tx_go && auto_en && is_abr && !i_tx_pending && !flags[i_tx_chan][0] &&
    cur[i_tx_chan] >= cfg[i_tx_chan].initp && !wr |=>
    flags[$past(i_tx_chan)][6])
    else $error("idle channel at initial rate not taken off list");

  AST_RM_FIRST: assert property (
    o_rm_sched |-> $past(rm_cnt) == '0 && rm_cnt == RMCNT_W'(1))
    else $error("RM schedule not on first entry");

  AST_MOVE_REG: assert property (
    move_wr && 32'(move_ch) < NCH && !tx_go &&
    prof[cur[move_ch]].kind == abr_pkg::ABR_KIND_ABR |=>
    cur[$past(move_ch)] == $past(move_prof))
    else $error("move register did not move channel");

endmodule
`default_nettype wire

// File: abr_traffic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module abr_traffic_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_valid = 1'b0;
  logic rx_ok = 1'b0, drain = 1'b0, pready, pslverr, err, tx_valid, tx_pend;
  logic rm_sched, rm_qappend, purge_valid, purge_all;
  logic [11:0] paddr = 12'h000, rx_chan = 12'h000, purge_chan;
  logic [31:0] pwdata = 32'h0000_0000, rx_hdr = 32'h0000_0000;
  logic [31:0] prdata, rd, h, seed = 32'h0000_18D0;
  logic [15:0] st, tx_status;
  logic [3:0] tx_chan;
  logic [1:0] bo, tx_boff;
  abr_pkg::abr_txcell_type tx_cell;
  abr_pkg::abr_route_type route;
  int failures = 0, compares = 0, cur, dc, oc;
  logic [31:0] hd [6] = '{32'h0000_100E, 32'h8000_1000, 32'h0000_1000,
                          32'h0000_1008, 32'h0000_100A, 32'h0000_100C};
  logic ok [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [15:0] ex [6] = '{16'h8012, 16'h8012, 16'h8012,
                          16'h8005, 16'h8005, 16'h0000};
  logic [15:0] mk [6] = '{16'hFFFA, 16'hFFFA, 16'hFFFA,
                          16'hFFFD, 16'hFFFD, 16'h8000};

  always #2 i_mclk = ~i_mclk;

  abr_traffic #(.NCH(16), .RMCNT_W(8)) u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tx_valid(tx_valid), .i_tx_chan(tx_chan),
    .i_tx_pending(tx_pend), .i_tx_status(tx_status), .i_tx_boff(tx_boff),
    .o_tx_cell(tx_cell), .i_rx_valid(rx_valid), .i_rx_hdr(rx_hdr),
    .i_rx_desc_ok(rx_ok), .i_rx_chan(rx_chan), .o_rx_route(route),
    .i_rm_drain(drain), .o_rm_sched(rm_sched), .o_rm_qappend(rm_qappend),
    .o_purge_valid(purge_valid), .o_purge_chan(purge_chan),
    .o_purge_all(purge_all));

  abr_host_model #(.NCH(16)) u_host (
    .i_mclk(i_mclk), .o_tx_valid(tx_valid), .o_tx_chan(tx_chan),
    .o_tx_pending(tx_pend), .o_tx_status(tx_status), .o_tx_boff(tx_boff));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Profile 1 decreases by two, the others by one; opportunity reload is 2.
  function automatic logic [14:0] abr_next(input logic [15:0] s,
                                           input logic [1:0] b);
    logic e;
    logic [4:0] p;
    p = 5'(cur);
    e = (oc > 1);
    oc = e ? oc - 1 : 2;
    if (dc <= ((cur == 1) ? 2 : 1)) begin
      cur = (cur < 3) ? cur + 1 : cur;
      dc = 3;
    end else begin
      dc = dc - ((cur == 1) ? 2 : 1);
    end
    return {1'b1, e, p, s[0], s[1], s[14], s[15], 4'hF << b};
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do
      @(posedge i_mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rx(input logic [31:0] hh, input logic k,
                    input logic [11:0] c, input logic [15:0] e,
                    input logic [15:0] m);
    @(posedge i_mclk);
    rx_valid <= 1'b1;
    rx_hdr <= hh;
    rx_ok <= k;
    rx_chan <= c;
    @(posedge i_mclk);
    rx_valid <= 1'b0;
    rx_hdr <= ~hh;
    #1 chk("route", 32'(e & m), 32'(16'(route) & m));
  endtask

  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl", 32'h0000_0001, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("range", 32'h00FF_FFFF, rd);
    apb(1'b0, 12'h7FC, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, rd | 32'(err));
    for (int p = 1; p < 4; p++) begin
      apb(1'b1, 12'h100 + 12'(4 * p),
          {8'h01, (p == 1) ? 8'h02 : 8'h01, 16'h0102});
    end
    apb(1'b0, 12'h108, 32'h0000_0000);
    chk("profile", 32'h0101_0102, rd);
    apb(1'b1, 12'h30C, 32'h0002_0003);
    apb(1'b1, 12'h20C, 32'h0001_0301);
    apb(1'b1, 12'h210, 32'h0000_0300);
    cur = 1;
    dc = 3;
    oc = 2;
    for (int i = 0; i < 10; i++) begin
      st = 16'(rnd());
      bo = 2'(rnd());
      u_host.send(4'h3, 1'b1, st, bo);
      #1 chk("tx_cell", 32'(abr_next(st, bo)),
             32'(tx_cell));
      u_host.send(4'h4, 1'b1, st, bo);
      #1 chk("cbr_profile", 32'h0000_0000, 32'(tx_cell.profile));
    end
    u_host.send(4'h3, 1'b0, 16'h0000, 2'h0);
    apb(1'b0, 12'h40C, 32'h0000_0000);
    chk("state", 32'h0042_0003, rd & 32'h0042_001F);
    apb(1'b1, 12'h000, 32'h0000_000D);
    for (int i = 0; i < 6; i++) begin
      rx(hd[i], ok[i], 12'h003, ex[i],
         mk[i]);
    end
    for (int i = 0; i < 4; i++) begin
      h = rnd();
      rx(h & 32'h00FF_FFF0, 1'b1, h[27:16], {1'b1, h[27:16], 3'h0},
         16'hFFF8);
    end
    apb(1'b0, 12'h40C, 32'h0000_0000);
    chk("rm_flag", 32'h0001_0000, rd & 32'h0001_0000);
    // A pending RM flag wins over the off-list restart on the next cell.
    u_host.send(4'h3, 1'b1, 16'h0000, 2'h0);
    apb(1'b0, 12'h40C, 32'h0000_0000);
    chk("raise", 32'h0000_0001, rd & 32'h0001_001F);
    apb(1'b1, 12'h000, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      rx(32'h0000_100C, 1'b1, 12'h003, 16'h800C, 16'hFFFC);
      @(posedge i_mclk);
      #1 chk("rm_sched", 32'(i == 0), 32'(rm_sched));
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("rm_count", 32'h0000_0002, rd);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_mclk);
      drain <= 1'b1;
      @(posedge i_mclk);
      drain <= 1'b0;
      #1 chk("rm_qappend", 32'(i == 1), 32'(rm_qappend));
    end
    apb(1'b1, 12'h000, 32'h0000_0003);
    rx(32'h0000_100C, 1'b1, 12'h003, 16'h800C, 16'hFFFC);
    apb(1'b1, 12'h004, 32'h0002_0003);
    apb(1'b0, 12'h40C, 32'h0000_0000);
    chk("move", 32'h0000_0002, rd & 32'h0000_001F);
    apb(1'b1, 12'h004, 32'h0002_0004);
    apb(1'b0, 12'h410, 32'h0000_0000);
    chk("cbr_move", 32'h0000_0000, rd & 32'h0000_001F);
    apb(1'b1, 12'h008, 32'h0001_0005);
    #1 chk("purge", 32'h0000_3005,
           {18'h0, purge_valid, purge_all, purge_chan});
    conclude();
  end
endmodule
`default_nettype wire
